// ---- sfr_cfg.svh ----
`ifndef SFR_CFG_SVH
`define SFR_CFG_SVH
// register offsets
`define SFR_A_CTRL 7'h00
`define SFR_A_SETP 7'h04
`define SFR_A_ONSET 7'h08
`define SFR_A_DUR 7'h0C
`define SFR_A_STR 7'h10
`define SFR_A_VDUR 7'h14
`define SFR_A_VSTR 7'h18
`define SFR_A_REF 7'h1C
`define SFR_A_LAUNCH 7'h20
`define SFR_A_THR 7'h24
`define SFR_A_JOGT 7'h28
`define SFR_A_JOGF 7'h2C
`define SFR_A_SHAPE 7'h30
`define SFR_A_STAT 7'h34
`define SFR_A_TIME0 7'h40
// control fields
`define SFR_CTRL_MODE 1:0
`define SFR_CTRL_SCURVE 2
`define SFR_CTRL_PREBRK 3
`define SFR_CTRL_METH 7:4
// ranges, 0.01 Hz / 0.1 s units
`define SFR_ONSET_LO 16'h0014
`define SFR_ONSET_HI 16'h07D0
`define SFR_DUR_LO 16'h0001
`define SFR_DUR_HI 16'h0064
`define SFR_STR_LO 16'h0001
`define SFR_STR_HI 16'h000A
`define SFR_REF_LO 16'h03E8
`define SFR_REF_HI 16'h2EE0
`define SFR_TIME_HI 16'hFDE8
`define SFR_JOGT_HI 16'h00C8
`define SFR_FREQ_HI 16'hEA60
// reset values
`define SFR_CTRL_RST 8'h01
`define SFR_REF_RST 16'h1388
`define SFR_DUR_RST 16'h0005
`define SFR_STR_RST 16'h0005
`define SFR_ONSET_RST 16'h0064
`define SFR_LAUNCH_RST 16'h0064
`define SFR_TIME_RST 16'h0032
`define SFR_SHAPE_RST 16'h0064
// timing
`define SFR_CLK_NS 20
`define SFR_TICK_NS 10000
`define SFR_TICK_CYC ((`SFR_TICK_NS + `SFR_CLK_NS - 1) / `SFR_CLK_NS)
`define SFR_DS_NS 100000000
`define SFR_TICKS_PER_DS (`SFR_DS_NS / `SFR_TICK_NS)
`endif

// ---- sfr_core.sv ----
// How it works
// - mode 1: stop ramps down on decel curve
// - mode 2: ramp to onset, then brake
// - mode 3: stop kills all gate drives
// - onset, duration, strength clamped to range
// - mode 2 ignores launch floor, brakes at onset
// - optional braking before start, then launch
// - low setpoint ramps to onset and brakes
// - setpoint above threshold keeps drive running
// - low setpoint: brake now if below onset
// - second stop ends braking at once
// - run during stop braking restarts drive
// - vector modes use separate brake settings
// - linear or s-curve, shape settable
// - both run inputs freeze frequency
// - new ramp times apply at next ramp
// - current limit makes s-curve linear
// - reference and ramp times clamped to range
// - slope is reference over ramp time
// - zero time means 0.1 s in V/f
// - two select inputs pick time pair
// - jog uses s-curve and jog time
`include "sfr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module sfr_core
  import sfr_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [6:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata_q,
  input wire logic fwd_run_pin,
  input wire logic rev_run_pin,
  input wire logic stop_key_pin,
  input wire logic inch_request_input,
  input wire logic ramp_select_bit0,
  input wire logic ramp_select_bit1,
  input wire logic current_limit_pin,
  output logic [15:0] out_freq_q,
  output logic rev_dir_q,
  output logic gate_en_q,
  output logic dcb_active_q,
  output logic [3:0] dcb_force_q
);
  function automatic logic [15:0] clampv(input logic [31:0] v, input logic [15:0] lo,
                                         input logic [15:0] hi);
    if (v[31:16] != 16'h0 || v[15:0] > hi) clampv = hi;
    else if (v[15:0] < lo) clampv = lo;
    else clampv = v[15:0];
  endfunction

  // 0.1 s units to 10 us ticks; zero kept only outside V/f
  function automatic logic [31:0] tdiv(input logic [15:0] t, input logic vec);
    logic [15:0] tt;
    tt = (t == 16'h0 && !vec) ? 16'h1 : t;
    tdiv = tt * 32'(`SFR_TICKS_PER_DS);
  endfunction

  // pin synchronisers: three stages, change taken once 2nd and 3rd agree
  logic [6:0] pin_w, s1_q, s2_q, s3_q, pf_q;
  assign pin_w = {current_limit_pin, ramp_select_bit1, ramp_select_bit0,
                  inch_request_input, stop_key_pin, rev_run_pin, fwd_run_pin};
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s1_q <= 7'h0;
      s2_q <= 7'h0;
      s3_q <= 7'h0;
      pf_q <= 7'h0;
    end else begin
      s1_q <= pin_w;
      s2_q <= s1_q;
      s3_q <= s2_q;
      pf_q <= (s2_q & s3_q) | (pf_q & (s2_q | s3_q));
    end
  end
  wire fwd_s = pf_q[0];
  wire rev_s = pf_q[1];
  wire stop_s = pf_q[2];
  wire jog_s = pf_q[3];
  wire [1:0] sel_s = pf_q[5:4];
  wire cl_s = pf_q[6];

  // register file
  logic [7:0] ctrl_q;
  logic [15:0] setp_q, onset_q, dur_q, str_q, vdur_q, vstr_q, ref_q, launch_q, thr_q;
  logic [15:0] jogt_q, jogf_q, shape_q;
  logic [15:0] tm_q [0:7];
  sfr_state_t st_q, st_d;
  wire [3:0] meth_w = ctrl_q[`SFR_CTRL_METH];
  wire vec_w = meth_w == 4'h2 || meth_w == 4'h5 || meth_w == 4'h8 || meth_w == 4'h9 ||
               meth_w == 4'hA || meth_w == 4'hC;
  wire wr_tm_w = reg_wr && reg_addr[6:5] == 2'b10 && reg_addr[1:0] == 2'b00;
  wire [2:0] tm_i = reg_addr[4:2];
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_q <= `SFR_CTRL_RST;
      setp_q <= 16'h0;
      onset_q <= `SFR_ONSET_RST;
      dur_q <= `SFR_DUR_RST;
      str_q <= `SFR_STR_RST;
      vdur_q <= `SFR_DUR_RST;
      vstr_q <= `SFR_STR_RST;
      ref_q <= `SFR_REF_RST;
      launch_q <= `SFR_LAUNCH_RST;
      thr_q <= 16'h0;
      jogt_q <= `SFR_TIME_RST;
      jogf_q <= `SFR_LAUNCH_RST;
      shape_q <= `SFR_SHAPE_RST;
      for (int i = 0; i < 8; i++) tm_q[i] <= `SFR_TIME_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        `SFR_A_CTRL: ctrl_q <= reg_wdata[7:0];
        `SFR_A_SETP: setp_q <= clampv(reg_wdata, 16'h0, `SFR_FREQ_HI);
        `SFR_A_ONSET: onset_q <= clampv(reg_wdata, `SFR_ONSET_LO, `SFR_ONSET_HI);
        `SFR_A_DUR: dur_q <= clampv(reg_wdata, `SFR_DUR_LO, `SFR_DUR_HI);
        `SFR_A_STR: str_q <= clampv(reg_wdata, `SFR_STR_LO, `SFR_STR_HI);
        `SFR_A_VDUR: vdur_q <= clampv(reg_wdata, `SFR_DUR_LO, `SFR_DUR_HI);
        `SFR_A_VSTR: vstr_q <= clampv(reg_wdata, `SFR_STR_LO, `SFR_STR_HI);
        `SFR_A_REF: ref_q <= clampv(reg_wdata, `SFR_REF_LO, `SFR_REF_HI);
        `SFR_A_LAUNCH: launch_q <= clampv(reg_wdata, 16'h0, `SFR_ONSET_HI);
        `SFR_A_THR: thr_q <= clampv(reg_wdata, 16'h0, `SFR_ONSET_HI);
        `SFR_A_JOGT: jogt_q <= clampv(reg_wdata, 16'h0, `SFR_JOGT_HI);
        // panel may set jog frequency only while a jog input is shorted
        `SFR_A_JOGF: if (jog_s) jogf_q <= clampv(reg_wdata, 16'h0, `SFR_FREQ_HI);
        `SFR_A_SHAPE: shape_q <= clampv(reg_wdata, 16'h1, 16'hFFFF);
        default: if (wr_tm_w) tm_q[tm_i] <= clampv(reg_wdata, 16'h0, `SFR_TIME_HI);
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) reg_rdata_q <= 32'h0;
    else if (reg_rd) begin
      case (reg_addr)
        `SFR_A_CTRL: reg_rdata_q <= {24'h0, ctrl_q};
        `SFR_A_SETP: reg_rdata_q <= {16'h0, setp_q};
        `SFR_A_ONSET: reg_rdata_q <= {16'h0, onset_q};
        `SFR_A_DUR: reg_rdata_q <= {16'h0, dur_q};
        `SFR_A_STR: reg_rdata_q <= {16'h0, str_q};
        `SFR_A_VDUR: reg_rdata_q <= {16'h0, vdur_q};
        `SFR_A_VSTR: reg_rdata_q <= {16'h0, vstr_q};
        `SFR_A_REF: reg_rdata_q <= {16'h0, ref_q};
        `SFR_A_LAUNCH: reg_rdata_q <= {16'h0, launch_q};
        `SFR_A_THR: reg_rdata_q <= {16'h0, thr_q};
        `SFR_A_JOGT: reg_rdata_q <= {16'h0, jogt_q};
        `SFR_A_JOGF: reg_rdata_q <= {16'h0, jogf_q};
        `SFR_A_SHAPE: reg_rdata_q <= {16'h0, shape_q};
        `SFR_A_STAT: reg_rdata_q <= {13'h0, st_q, out_freq_q};
        default: reg_rdata_q <= (reg_addr[6:5] == 2'b10 && reg_addr[1:0] == 2'b00) ?
                                {16'h0, tm_q[tm_i]} : 32'h0;
      endcase
    end else reg_rdata_q <= 32'h0;
  end

  // command decode
  logic stop_p_q, halt_q, lock_p_q;
  wire any_run_w = fwd_s | rev_s | jog_s;
  wire run_w = any_run_w & !halt_q;
  wire lock_w = fwd_s & rev_s;
  wire stop_edge_w = stop_s & !stop_p_q;
  wire stop_req_w = stop_edge_w | !run_w;
  wire [15:0] sp_w = jog_s ? jogf_q : setp_q;
  wire low_w = sp_w < thr_q;
  wire startok_w = !low_w && sp_w >= launch_q;
  wire [1:0] mode_w = ctrl_q[`SFR_CTRL_MODE];
  wire [31:0] bdiv_w = tdiv(vec_w ? vdur_q : dur_q, 1'b1);
  wire [3:0] bstr_w = vec_w ? vstr_q[3:0] : str_q[3:0];
  logic [31:0] bcnt_q;
  logic brk_end_q;
  wire bdone_w = bcnt_q >= bdiv_w;
  wire above_w = out_freq_q > onset_q;
  wire [15:0] floor_w = brk_end_q ? onset_q : launch_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stop_p_q <= 1'b0;
      halt_q <= 1'b0;
      lock_p_q <= 1'b0;
    end else begin
      stop_p_q <= stop_s;
      lock_p_q <= lock_w;
      if (stop_edge_w) halt_q <= 1'b1;
      else if (!any_run_w) halt_q <= 1'b0;
    end
  end

  // stop sequencer
  logic brk_end_d;
  always_comb begin
    st_d = st_q;
    brk_end_d = brk_end_q;
    case (st_q)
      SFR_IDLE: if (run_w && startok_w) st_d = ctrl_q[`SFR_CTRL_PREBRK] ? SFR_PRE : SFR_RUN;
      SFR_PRE: begin
        if (stop_req_w) st_d = SFR_IDLE;
        else if (bdone_w) st_d = SFR_RUN;
      end
      SFR_RUN: begin
        if (stop_req_w) begin
          if (mode_w == 2'h3) st_d = SFR_COAST;
          else if (mode_w == 2'h2) begin
            st_d = above_w ? SFR_DECEL : SFR_DCB;
            brk_end_d = 1'b1;
          end else begin
            st_d = SFR_DECEL;
            brk_end_d = 1'b0;
          end
        end else if (low_w) begin
          // output above onset: ramp to onset first, otherwise brake at once
          st_d = above_w ? SFR_DECEL : SFR_DCB;
          brk_end_d = 1'b1;
        end
      end
      SFR_DECEL: begin
        if (stop_edge_w && mode_w == 2'h3) st_d = SFR_COAST;
        else if (out_freq_q <= floor_w) st_d = brk_end_q ? SFR_DCB : SFR_IDLE;
        else if (run_w && !low_w) st_d = SFR_RUN;
      end
      SFR_DCB: begin
        if (stop_edge_w) st_d = SFR_IDLE;
        else if (bdone_w) st_d = SFR_IDLE;
        else if (run_w && startok_w) st_d = SFR_IDLE;
      end
      SFR_COAST: st_d = SFR_IDLE;
      default: st_d = SFR_IDLE;
    endcase
  end

  // ramp engine
  logic [8:0] tick_cnt_q;
  logic [31:0] div_q, acc_q;
  logic [15:0] tgt_p_q, sc_cnt_q;
  logic [3:0] k_q;
  logic ramping_q, dirup_q, lin_q;
  wire tick_w = tick_cnt_q == 9'(`SFR_TICK_CYC - 1);
  wire [15:0] tgt_w = (st_q == SFR_RUN) ? (lock_w ? out_freq_q : sp_w) :
                      (st_q == SFR_DECEL) ? floor_w : out_freq_q;
  wire up_w = tgt_w > out_freq_q;
  wire ramp_w = up_w || tgt_w < out_freq_q;
  wire new_ramp_w = ramp_w && (!ramping_q || up_w != dirup_q);
  wire [2:0] ti_w = {!up_w, sel_s};
  wire [15:0] tsel_w = jog_s ? jogt_q : tm_q[ti_w];
  wire [31:0] div_w = new_ramp_w ? tdiv(tsel_w, vec_w) : div_q;
  wire s_w = ctrl_q[`SFR_CTRL_SCURVE] | jog_s;
  wire [15:0] dist_w = up_w ? tgt_w - out_freq_q : out_freq_q - tgt_w;
  wire near_w = dist_w < {4'h0, ref_q[15:4]};
  wire restart_w = new_ramp_w || tgt_w != tgt_p_q || (lock_p_q && !lock_w);
  wire [19:0] kref_w = ref_q * k_q;
  // s-curve scales the slope by k/8; linear runs at full reference slope
  wire [15:0] inc_w = (s_w && !lin_q) ? kref_w[18:3] : ref_q;
  wire step_w = ramp_w && div_w != 32'h0 && acc_q >= div_w;
  wire [31:0] acc_d = acc_q - (step_w ? div_w : 32'h0) +
                      ((tick_w && ramp_w) ? {16'h0, inc_w} : 32'h0);
  logic [15:0] freq_d;
  always_comb begin
    freq_d = out_freq_q;
    if (st_d == SFR_RUN && (st_q == SFR_IDLE || st_q == SFR_PRE)) freq_d = launch_q;
    else if (st_d == SFR_IDLE || st_d == SFR_COAST || st_d == SFR_DCB) freq_d = 16'h0;
    else if (ramp_w && div_w == 32'h0) freq_d = tgt_w;
    else if (step_w) freq_d = up_w ? out_freq_q + 16'h1 : out_freq_q - 16'h1;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tick_cnt_q <= 9'h0;
      div_q <= 32'h0;
      acc_q <= 32'h0;
      tgt_p_q <= 16'h0;
      ramping_q <= 1'b0;
      dirup_q <= 1'b0;
      out_freq_q <= 16'h0;
    end else begin
      tick_cnt_q <= tick_w ? 9'h0 : tick_cnt_q + 9'h1;
      div_q <= div_w;
      acc_q <= ramp_w ? (new_ramp_w ? 32'h0 : acc_d) : 32'h0;
      tgt_p_q <= tgt_w;
      ramping_q <= ramp_w;
      dirup_q <= up_w;
      out_freq_q <= freq_d;
    end
  end

  // s-curve shaping: slope factor climbs then falls near target
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      k_q <= 4'h1;
      sc_cnt_q <= 16'h0;
      lin_q <= 1'b0;
    end else begin
      if (new_ramp_w) lin_q <= 1'b0;
      else if (cl_s && ramp_w && s_w) lin_q <= 1'b1;
      if (restart_w) begin
        k_q <= 4'h1;
        sc_cnt_q <= 16'h0;
      end else if (tick_w) begin
        sc_cnt_q <= (sc_cnt_q >= shape_q - 16'h1) ? 16'h0 : sc_cnt_q + 16'h1;
        if (sc_cnt_q >= shape_q - 16'h1) begin
          if (near_w && k_q > 4'h1) k_q <= k_q - 4'h1;
          else if (!near_w && k_q < 4'h8) k_q <= k_q + 4'h1;
        end
      end
    end
  end

  // state, brake timer, outputs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q <= SFR_IDLE;
      brk_end_q <= 1'b0;
      bcnt_q <= 32'h0;
      gate_en_q <= 1'b0;
      dcb_active_q <= 1'b0;
      dcb_force_q <= 4'h0;
      rev_dir_q <= 1'b0;
    end else begin
      st_q <= st_d;
      brk_end_q <= brk_end_d;
      bcnt_q <= (st_d != st_q) ? 32'h0 : (tick_w ? bcnt_q + 32'h1 : bcnt_q);
      gate_en_q <= st_d != SFR_IDLE && st_d != SFR_COAST;
      dcb_active_q <= st_d == SFR_PRE || st_d == SFR_DCB;
      dcb_force_q <= (st_d == SFR_PRE || st_d == SFR_DCB) ? bstr_w : 4'h0;
      if (st_q == SFR_IDLE && st_d != SFR_IDLE) rev_dir_q <= rev_s & !fwd_s;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  coast_gate_off_a: assert property ((st_q == SFR_RUN && stop_req_w && mode_w == 2'h3) |=>
    !gate_en_q ##1 st_q == SFR_IDLE && !gate_en_q) else $error("coast left gates on");
  brake_zero_freq_a: assert property (dcb_active_q |-> out_freq_q == 16'h0 && gate_en_q)
    else $error("braking with frequency");
  stop_ends_brake_a: assert property ((st_q == SFR_DCB && stop_edge_w) |=>
    st_q == SFR_IDLE ##1 !dcb_active_q) else $error("stop did not end braking");
  lock_freeze_a: assert property ((st_q == SFR_RUN && st_d == SFR_RUN && lock_w) |=>
    out_freq_q == $past(out_freq_q)) else $error("lock did not freeze");
  slope_hold_a: assert property ((ramping_q && ramp_w && up_w == dirup_q) |->
    div_w == div_q) else $error("ramp time changed mid ramp");
  zero_time_a: assert property ((new_ramp_w && !vec_w) |=> div_q != 32'h0)
    else $error("zero ramp time in V/f");
  limit_linear_a: assert property ((cl_s && ramp_w && s_w && !new_ramp_w) |=>
    lin_q && inc_w == ref_q) else $error("s-curve kept under limit");
  s_restart_a: assert property ((ramping_q && ramp_w && tgt_w != tgt_p_q) |=>
    k_q == 4'h1) else $error("s-curve not restarted");
  low_brake_now_a: assert property ((st_q == SFR_RUN && run_w && !stop_edge_w && low_w &&
    !above_w) |=> st_q == SFR_DCB && dcb_active_q) else $error("no immediate brake");
endmodule
`default_nettype wire

// ---- sfr_pkg.sv ----
package sfr_pkg;
  typedef enum logic [2:0] {
    SFR_IDLE = 3'h0,
    SFR_PRE = 3'h1,
    SFR_RUN = 3'h3,
    SFR_DECEL = 3'h2,
    SFR_DCB = 3'h6,
    SFR_COAST = 3'h7
  } sfr_state_t;
endpackage

// ---- sfr_stage_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module sfr_stage_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [15:0] out_freq_q,
  input wire logic gate_en_q,
  input wire logic [15:0] limit_freq,
  output logic current_limit_pin
);
  // stage current grows with frequency; limit engages at or above limit_freq
  // only while the gates switch, since a coasting stage draws no current
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      current_limit_pin <= 1'b0;
    end else begin
      current_limit_pin <= gate_en_q && (limit_freq != 16'h0000) && (out_freq_q >= limit_freq);
    end
  end
endmodule
`default_nettype wire

// ---- stop_mode_and_frequency_ramp_tb.sv ----
`include "sfr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module stop_mode_and_frequency_ramp_tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [6:0] reg_addr = 7'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, rd_seen = 1'b0;
  logic fwd = 1'b0, rev = 1'b0, stop_key = 1'b0, inch = 1'b0, sel0 = 1'b0, sel1 = 1'b0;
  logic cl, rev_dir_q, gate_en_q, dcb_active_q;
  logic [31:0] reg_rdata_q;
  logic [15:0] out_freq_q, f, lim_f = 16'h0;
  logic [3:0] dcb_force_q;
  logic [31:0] exp_q[$];
  int fail_count = 0, compares = 0, n;
  localparam logic [6:0] RA[10] = '{7'h00, 7'h1C, 7'h0C, 7'h10, 7'h08, 7'h20, 7'h40, 7'h30,
    7'h34, 7'h7C};
  localparam logic [15:0] RE[10] = '{16'h1, 16'h1388, 16'h5, 16'h5, 16'h64, 16'h64, 16'h32,
    16'h64, 16'h0, 16'h0};
  localparam logic [6:0] CA[10] = '{7'h08, 7'h08, 7'h0C, 7'h0C, 7'h10, 7'h10, 7'h1C, 7'h1C,
    7'h40, 7'h28};
  localparam logic [15:0] CD[10] = '{16'h0, 16'hFFFF, 16'h0, 16'hFFFF, 16'h0, 16'hFF, 16'h0,
    16'hFFFF, 16'hFFFF, 16'hFFFF};
  localparam logic [15:0] CE[10] = '{16'h14, 16'h7D0, 16'h1, 16'h64, 16'h1, 16'hA, 16'h3E8,
    16'h2EE0, 16'hFDE8, 16'hC8};

  sfr_core sfr_core_i (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .fwd_run_pin(fwd), .rev_run_pin(rev), .stop_key_pin(stop_key),
    .inch_request_input(inch), .ramp_select_bit0(sel0), .ramp_select_bit1(sel1),
    .current_limit_pin(cl), .out_freq_q(out_freq_q), .rev_dir_q(rev_dir_q),
    .gate_en_q(gate_en_q), .dcb_active_q(dcb_active_q), .dcb_force_q(dcb_force_q));
  sfr_stage_model sfr_stage_model_i (.clk(clk), .sys_rst(sys_rst), .out_freq_q(out_freq_q),
    .gate_en_q(gate_en_q), .limit_freq(lim_f), .current_limit_pin(cl));

  always #10 clk = ~clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, want);
    end
  endtask

  // read data stands only one cycle after the strobe, so the watcher pairs them
  always @(posedge clk) begin
    rd_seen <= reg_rd;
    if (rd_seen) check(reg_rdata_q, exp_q.pop_front());
  end

  task automatic ticks(input int k);
    repeat (k) @(posedge clk);
  endtask

  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [6:0] a, input logic [31:0] want);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back(want);
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask

  function automatic logic [15:0] pick(input int w);
    case (w)
      0: pick = out_freq_q;
      1: pick = {15'h0, gate_en_q};
      2: pick = {15'h0, dcb_active_q};
      3: pick = {12'h0, dcb_force_q};
      default: pick = {15'h0, rev_dir_q};
    endcase
  endfunction

  // bounded wait, sampled mid-cycle where outputs have settled
  task automatic see(input int w, input logic [15:0] v, input int lim);
    int k;
    k = 0;
    @(negedge clk);
    while (k < lim && pick(w) !== v) begin
      @(negedge clk);
      k++;
    end
    check({16'h0, pick(w)}, {16'h0, v});
    @(posedge clk);
  endtask

  // held past the pin filter so the edge is surely seen
  task automatic stop_press;
    stop_key <= 1'b1;
    ticks(8);
    stop_key <= 1'b0;
    ticks(8);
  endtask

  task automatic conclude;
    if (fail_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge clk);
    fail_count++;
    conclude;
  end

  initial begin
    void'($urandom(32'hef445140));
    ticks(16);
    sys_rst <= 1'b0;
    ticks(2);
    for (int i = 0; i < 10; i++) rd(RA[i], {16'h0, RE[i]});
    for (int i = 0; i < 10; i++) begin
      wr(CA[i], {16'h0, CD[i]});
      rd(CA[i], {16'h0, CE[i]});
    end
    wr(`SFR_A_SETP, 32'h69);
    wr(7'h40, 32'h0);
    wr(7'h50, 32'h0);
    fwd <= 1'b1;
    see(1, 16'h1, 20);
    n = 0;
    while (n < 5000 && out_freq_q !== 16'h0069) begin
      @(negedge clk);
      n++;
    end
    check(32'(n >= 1500 && n <= 3500), 32'h1);
    @(posedge clk);
    fwd <= 1'b0;
    ticks(600);
    see(1, 16'h1, 0);
    see(1, 16'h0, 5000);
    see(0, 16'h0, 2);
    wr(`SFR_A_CTRL, 32'h3);
    fwd <= 1'b1;
    see(1, 16'h1, 20);
    stop_press;
    see(1, 16'h0, 0);
    see(0, 16'h0, 0);
    fwd <= 1'b0;
    ticks(8);
    wr(`SFR_A_ONSET, 32'h5A);
    wr(`SFR_A_CTRL, 32'h2);
    fwd <= 1'b1;
    see(0, 16'h69, 4000);
    stop_press;
    see(0, 16'h5F, 6000);
    see(2, 16'h1, 4000);
    see(3, 16'hA, 0);
    see(0, 16'h0, 0);
    stop_press;
    see(2, 16'h0, 0);
    fwd <= 1'b0;
    wr(`SFR_A_ONSET, 32'h7D0);
    wr(`SFR_A_THR, 32'h64);
    fwd <= 1'b1;
    see(0, 16'h69, 4000);
    wr(`SFR_A_SETP, 32'h50);
    see(2, 16'h1, 20);
    stop_press;
    fwd <= 1'b0;
    wr(`SFR_A_ONSET, 32'h5A);
    wr(`SFR_A_THR, 32'h68);
    wr(`SFR_A_SETP, 32'h69);
    fwd <= 1'b1;
    see(0, 16'h69, 4000);
    wr(`SFR_A_SETP, 32'h66);
    see(2, 16'h1, 10000);
    stop_press;
    fwd <= 1'b0;
    wr(`SFR_A_THR, 32'h0);
    wr(`SFR_A_SETP, 32'h69);
    wr(`SFR_A_CTRL, 32'h22);
    fwd <= 1'b1;
    see(0, 16'h69, 1500);
    fwd <= 1'b0;
    see(2, 16'h1, 1500);
    see(3, 16'h5, 0);
    fwd <= 1'b1;
    see(2, 16'h0, 20);
    see(1, 16'h1, 600);
    fwd <= 1'b0;
    see(2, 16'h1, 1500);
    stop_press;
    see(2, 16'h0, 0);
    wr(`SFR_A_CTRL, 32'h9);
    fwd <= 1'b1;
    see(2, 16'h1, 20);
    see(3, 16'hA, 0);
    rd(`SFR_A_STAT, 32'h0001_0000);
    stop_press;
    fwd <= 1'b0;
    wr(`SFR_A_CTRL, 32'h1);
    wr(`SFR_A_SETP, 32'hC8);
    fwd <= 1'b1;
    see(0, 16'h66, 4000);
    wr(7'h40, 32'hFDE8);
    see(0, 16'h6A, 3000);
    rev <= 1'b1;
    ticks(8);
    @(negedge clk);
    f = out_freq_q;
    @(posedge clk);
    lim_f <= 16'h0064;
    ticks(2000);
    @(negedge clk);
    check({16'h0, out_freq_q}, {16'h0, f});
    @(posedge clk);
    wr(`SFR_A_CTRL, 32'h3);
    stop_press;
    fwd <= 1'b0;
    rev <= 1'b0;
    lim_f <= 16'h0;
    wr(`SFR_A_CTRL, 32'h21);
    for (int k = 0; k < 4; k++) wr(7'h50 + 7'(4 * k), 32'h0);
    for (int s = 0; s < 4; s++) begin
      for (int k = 0; k < 4; k++) wr(7'h40 + 7'(4 * k), (k == s) ? 32'h0 : 32'hFFF);
      f = 16'(110 + $urandom % 400);
      wr(`SFR_A_SETP, {16'h0, f});
      {sel1, sel0} <= 2'(s);
      fwd <= 1'(s % 2 == 0);
      rev <= 1'(s % 2);
      see(0, f, 1500);
      see(4, 16'(s % 2), 0);
      fwd <= 1'b0;
      rev <= 1'b0;
      see(1, 16'h0, 1500);
    end
    inch <= 1'b1;
    ticks(8);
    wr(`SFR_A_JOGF, 32'h6E);
    rd(`SFR_A_JOGF, 32'h6E);
    see(1, 16'h1, 20);
    inch <= 1'b0;
    ticks(8);
    wr(`SFR_A_JOGF, 32'h77);
    rd(`SFR_A_JOGF, 32'h6E);
    ticks(4);
    conclude;
  end
endmodule
`default_nettype wire
